// file: dv/ram_blk_sva.sv
`timescale 1ns/10ps
`default_nettype none
module ram_blk_sva (
  // Clock and reset
  input wire logic                  sys_clk,
  input wire logic                  rst,
  // Inputs of the block
  input wire logic                  clk_en,
  input wire logic                  wr_clk_en,
  input wire logic                  rd_clk_en,
  input wire ram_blk_pkg::ram_req_t a_req,
  input wire ram_blk_pkg::ram_req_t b_req,
  // Outputs of the block
  input wire logic [15:0]           a_rdata,
  input wire logic [15:0]           b_rdata,
  input wire logic                  wr_collide,
  input wire logic                  mixed_rdw
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_reset_zero: assert property ($fell(rst) |->
    a_rdata == 16'h0000 && b_rdata == 16'h0000 && !mixed_rdw &&
    !wr_collide) else $error("outputs not zero");
  a_idle_hold: assert property (!clk_en |=> $stable(a_rdata) &&
    $stable(b_rdata)) else $error("read data moved while disabled");
  a_idle_flags: assert property (!clk_en |=>
    !wr_collide && !mixed_rdw) else $error("flag raised while disabled");
  a_a_new_data: assert property (clk_en && a_req.wr_en &&
    a_req.byte_en == 2'b11 && !a_req.addr_hold |=>
    a_rdata == $past(a_req.data)) else $error("port a new data missing");
  a_b_new_data: assert property (clk_en && b_req.wr_en &&
    b_req.byte_en == 2'b11 && !b_req.addr_hold |=>
    b_rdata == $past(b_req.data)) else $error("port b new data missing");
  a_low_byte: assert property (clk_en && a_req.wr_en &&
    a_req.byte_en == 2'b01 && !a_req.addr_hold |=>
    a_rdata[7:0] == $past(a_req.data[7:0])) else $error("byte lane wrong");
  a_mixed_flag: assert property (clk_en && a_req.wr_en &&
    b_req.rd_en && !b_req.wr_en && !a_req.addr_hold && !b_req.addr_hold &&
    a_req.addr == b_req.addr |=> mixed_rdw) else $error("mixed flag missing");
  a_mixed_cause: assert property (mixed_rdw |-> $past(clk_en))
    else $error("mixed flag without access");
  a_read_stands: assert property (clk_en && !a_req.rd_en &&
    !a_req.wr_en |=> $stable(a_rdata)) else $error("port a data moved");
  a_collide_cause: assert property (wr_collide |->
    $past(a_req.wr_en && b_req.wr_en)) else $error("collide without writes");
endmodule
bind ram_blk ram_blk_sva i_sva (.sys_clk(sys_clk), .rst(rst),
  .clk_en(clk_en), .wr_clk_en(wr_clk_en), .rd_clk_en(rd_clk_en),
  .a_req(a_req), .b_req(b_req), .a_rdata(a_rdata), .b_rdata(b_rdata),
  .wr_collide(wr_collide), .mixed_rdw(mixed_rdw));
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam logic [256*16-1:0] INIT = {{255{16'h0000}}, 16'h00ff};
  typedef struct { int due; int sel; logic [15:0] exp; } note_t;
  logic                  sys_clk = 1'b0;
  logic                  rst     = 1'b1;
  ram_blk_pkg::ram_req_t a_req, b_req, ra, rb;
  logic                  clk_en, wr_clk_en, rd_clk_en, wr_collide, mixed_rdw;
  logic [15:0]           a_rdata, b_rdata;
  logic [15:0]           mem [256];
  logic [7:0]            la = 8'h00, lb = 8'h00;
  note_t                 notes[$], n;
  int                    ncnt = 0, error_cnt = 0, checks = 0, seed = 20;

  ram_blk #(.INIT_IMAGE(INIT)) i_dut (.sys_clk(sys_clk), .rst(rst),
    .clk_en(clk_en), .wr_clk_en(wr_clk_en), .rd_clk_en(rd_clk_en),
    .a_req(a_req), .b_req(b_req), .a_rdata(a_rdata), .b_rdata(b_rdata),
    .wr_collide(wr_collide), .mixed_rdw(mixed_rdw));
  user_side i_usr (.sys_clk(sys_clk), .a_req(a_req), .b_req(b_req),
    .clk_en(clk_en), .wr_clk_en(wr_clk_en), .rd_clk_en(rd_clk_en));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask

  function automatic ram_blk_pkg::ram_req_t rq(input logic [7:0] ad,
    input logic [15:0] d, input logic [1:0] be, input logic w, r);
    rq = '{ad, d, be, w, r, 1'b0};
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] o,
                                        input ram_blk_pkg::ram_req_t r);
    for (int i = 0; i < 2; i++) begin
      if (r.byte_en[i]) o[i*8 +: 8] = r.data[i*8 +: 8];
    end
    return o;
  endfunction

  // Expectations are noted when the request is launched; the edge after
  // launch takes it, so its result is due one watcher tick later.
  task automatic op(input ram_blk_pkg::ram_req_t a, b, input logic en);
    ram_blk_pkg::ram_req_t bo;
    logic [7:0]  ea, eb;
    logic [15:0] oa, ob, na, nb;
    logic        mx;
    i_usr.drive(a, b, en, bo);
    ea = a.addr_hold ? la : a.addr;
    eb = bo.addr_hold ? lb : bo.addr;
    mx = 1'b0;
    if (en) begin
      oa = mem[ea];
      ob = mem[eb];
      na = merge(oa, a);
      nb = merge(ob, bo);
      mx = ea == eb && ((a.wr_en && bo.rd_en) || (bo.wr_en && a.rd_en));
      if (a.wr_en) mem[ea] = na;
      if (bo.wr_en) mem[eb] = nb;
      if (a.wr_en || a.rd_en) notes.push_back('{ncnt + 1, 0,
        a.wr_en ? na : oa});
      if (bo.wr_en || bo.rd_en) notes.push_back('{ncnt + 1, 1,
        bo.wr_en ? nb : ob});
      if (!a.addr_hold) la = a.addr;
      if (!bo.addr_hold) lb = bo.addr;
    end
    notes.push_back('{ncnt + 1, 2, {15'h0000, mx}});
  endtask

  always @(negedge sys_clk) begin
    while (notes.size() > 0 && notes[0].due == ncnt) begin
      n = notes.pop_front();
      case (n.sel)
        0:       chk("a_rdata", n.exp, a_rdata);
        1:       chk("b_rdata", n.exp, b_rdata);
        default: chk("flags", n.exp, {14'h0000, wr_collide, mixed_rdw});
      endcase
    end
    ncnt++;
  end

  task automatic complete_run();
    $display("Counts: %0d checks, %0d mismatches", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100000;
    error_cnt++;
    complete_run();
  end

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = INIT[i*16 +: 16];
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk("a_rdata", 16'h0000, a_rdata);
    chk("b_rdata", 16'h0000, b_rdata);
    op(rq(8'h00, 16'h0000, 2'b00, 1'b0, 1'b1), rq(8'h01, 16'h0000, 2'b00,
       1'b0, 1'b1), 1'b1);
    $display("Test power-up done");
    op(rq(8'h05, 16'h1234, 2'b11, 1'b1, 1'b0), rq(8'h06, 16'habcd, 2'b11,
       1'b1, 1'b1), 1'b1);
    op(rq(8'h05, 16'h5678, 2'b01, 1'b1, 1'b1), rq(8'h06, 16'hff00, 2'b10,
       1'b1, 1'b0), 1'b1);
    $display("Test same-port done");
    op(rq(8'h05, 16'h9999, 2'b11, 1'b1, 1'b0), rq(8'h05, 16'h0000, 2'b00,
       1'b0, 1'b1), 1'b1);
    op(rq(8'h06, 16'h0000, 2'b00, 1'b0, 1'b1), rq(8'h06, 16'h7777, 2'b11,
       1'b1, 1'b0), 1'b1);
    $display("Test mixed-port done");
    op(rq(8'h07, 16'hdead, 2'b11, 1'b1, 1'b1), rq(8'h07, 16'hbeef, 2'b11,
       1'b1, 1'b1), 1'b0);
    op(rq(8'h07, 16'h0000, 2'b00, 1'b0, 1'b1), '0, 1'b1);
    ra = rq(8'h06, 16'h0000, 2'b00, 1'b0, 1'b1);
    ra.addr_hold = 1'b1;
    op(ra, '0, 1'b1);
    $display("Test enable and hold done");
    repeat (300) begin
      ra = 29'($random(seed));
      rb = 29'($random(seed));
      ra.addr[7:3] = 5'h00;
      rb.addr[7:3] = 5'h00;
      op(ra, rb, ($random(seed) & 3) != 0);
    end
    repeat (3) op('0, '0, 1'b1);
    while (notes.size() != 0) @(negedge sys_clk);
    $display("Test random done");
    complete_run();
  end
endmodule
`default_nettype wire

// file: dv/user_side.sv
`timescale 1ns/10ps
`default_nettype none
module user_side (
  // Clock
  input  wire logic                  sys_clk,
  // Requests toward the block
  output var ram_blk_pkg::ram_req_t  a_req,
  output var ram_blk_pkg::ram_req_t  b_req,
  output logic                       clk_en,
  output logic                       wr_clk_en,
  output logic                       rd_clk_en
);
  initial begin
    a_req     = '0;
    b_req     = '0;
    clk_en    = 1'b0;
    wr_clk_en = 1'b0;
    rd_clk_en = 1'b0;
  end
  // Both ports share sys_clk, so no cross-clock read-during-write arises.
  // A held address may alias the other port, so B yields on any doubt.
  task automatic drive(input ram_blk_pkg::ram_req_t a,
                       input ram_blk_pkg::ram_req_t b, input logic en,
                       output ram_blk_pkg::ram_req_t bo);
    bo = b;
    if (a.wr_en && b.wr_en && (a.addr == b.addr || a.addr_hold ||
        b.addr_hold)) begin
      bo.wr_en = 1'b0;
    end
    @(posedge sys_clk);
    a_req     <= a;
    b_req     <= bo;
    clk_en    <= en;
    wr_clk_en <= ~en;
    rd_clk_en <= en;
  endtask
endmodule
`default_nettype wire

// file: rtl/ram_array.sv
`timescale 1ns/10ps
`default_nettype none
module ram_array #(
  parameter int ADDR_W = ram_blk_pkg::ADDR_W,
  parameter int DATA_W = ram_blk_pkg::DATA_W,
  parameter int BYTE_W = ram_blk_pkg::BYTE_W,
  parameter logic [(1<<ADDR_W)*DATA_W-1:0] INIT_IMAGE = '0
) (
  // Clock
  input  wire logic                          sys_clk,
  // Write ports
  input  wire logic [1:0]                    wr_go,
  input  wire logic [1:0][ADDR_W-1:0]        wr_addr,
  input  wire logic [1:0][DATA_W-1:0]        wr_data,
  input  wire logic [1:0][DATA_W/BYTE_W-1:0] wr_be,
  // Read ports, contents before this edge's writes
  input  wire logic [1:0][ADDR_W-1:0]        rd_addr,
  output logic      [1:0][DATA_W-1:0]        rd_old
);

  localparam int DEPTH = 1 << ADDR_W;
  localparam int BYTES = DATA_W / BYTE_W;

  typedef logic [DATA_W-1:0] mem_t [DEPTH];

  // ----------------------------------------------------------------------
  // Preload
  // ----------------------------------------------------------------------
  function automatic mem_t load_image();
    mem_t m;
    for (int i = 0; i < DEPTH; i++) begin
      m[i] = INIT_IMAGE[i*DATA_W +: DATA_W];
    end
    return m;
  endfunction

  // The array has no clear of any kind; only written data changes it.
  mem_t mem = load_image();

  // ----------------------------------------------------------------------
  // Write
  // ----------------------------------------------------------------------
  // Port B is applied last, so a same-address double write keeps B's bytes.
  always_ff @(posedge sys_clk) begin
    for (int p = 0; p < 2; p++) begin
      for (int b = 0; b < BYTES; b++) begin
        if (wr_go[p] && wr_be[p][b]) begin
          mem[wr_addr[p]][b*BYTE_W +: BYTE_W] <=
            wr_data[p][b*BYTE_W +: BYTE_W];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read
  // ----------------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      rd_old[p] = mem[rd_addr[p]];
    end
  end

endmodule
`default_nettype wire

// file: rtl/ram_blk.sv
`timescale 1ns/10ps
`default_nettype none
module ram_blk #(
  parameter int                       ADDR_W     = ram_blk_pkg::ADDR_W,
  parameter int                       DATA_W     = ram_blk_pkg::DATA_W,
  parameter ram_blk_pkg::clk_scheme_t CLK_SCHEME = ram_blk_pkg::SCHEME_SINGLE,
  parameter ram_blk_pkg::ram_cfg_t    RAM_CFG    = ram_blk_pkg::CFG_TRUE_DUAL,
  parameter logic [1:0]               OUT_REG    = 2'b00,
  parameter logic [(1<<ADDR_W)*DATA_W-1:0] INIT_IMAGE = '0
) (
  // Clock and power-up reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // Clock enables
  input  wire logic                  clk_en,
  input  wire logic                  wr_clk_en,
  input  wire logic                  rd_clk_en,
  // Port requests
  input  wire ram_blk_pkg::ram_req_t a_req,
  input  wire ram_blk_pkg::ram_req_t b_req,
  // Read data
  output logic [DATA_W-1:0]          a_rdata,
  output logic [DATA_W-1:0]          b_rdata,
  // Contention status, one cycle each
  output logic                       wr_collide,
  output logic                       mixed_rdw
);

  localparam int BYTE_W = ram_blk_pkg::BYTE_W;
  localparam int BYTES  = DATA_W / BYTE_W;
  localparam int PORTS  = ram_blk_pkg::PORTS;

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  // The request struct is fixed by the package, so the widths must match.
  if (ADDR_W != ram_blk_pkg::ADDR_W) begin : g_bad_addr
    $error("ram_blk: ADDR_W must equal the package address width");
  end
  if (DATA_W != ram_blk_pkg::DATA_W) begin : g_bad_data
    $error("ram_blk: DATA_W must equal the package data width");
  end
  if (DATA_W % BYTE_W != 0) begin : g_bad_bytes
    $error("ram_blk: DATA_W must be a whole number of bytes");
  end
  // Split clocking exists only for the simple dual-port arrangement.
  if (CLK_SCHEME == ram_blk_pkg::SCHEME_SPLIT &&
      RAM_CFG != ram_blk_pkg::CFG_SIMPLE_DUAL) begin : g_bad_scheme
    $error("ram_blk: split clocking needs the simple dual-port arrangement");
  end

  // ----------------------------------------------------------------------
  // Request fan-in
  // ----------------------------------------------------------------------
  ram_blk_pkg::ram_req_t req [PORTS];

  assign req[ram_blk_pkg::PORT_A] = a_req;
  assign req[ram_blk_pkg::PORT_B] = b_req;

  // ----------------------------------------------------------------------
  // Per-port capture logic
  // ----------------------------------------------------------------------
  logic [PORTS-1:0]             port_ce;
  logic [PORTS-1:0]             wr_go;
  logic [PORTS-1:0]             rd_go;
  logic [PORTS-1:0][ADDR_W-1:0] eff_addr;
  logic [PORTS-1:0][DATA_W-1:0] wr_data;
  logic [PORTS-1:0][BYTES-1:0]  wr_be;
  logic [PORTS-1:0][DATA_W-1:0] rd_old;
  logic [DATA_W-1:0]            rdata [PORTS];

  for (genvar p = 0; p < PORTS; p++) begin : g_port

    // Which operations the arrangement lets this port perform.
    localparam bit ALLOW_WR =
      (RAM_CFG == ram_blk_pkg::CFG_TRUE_DUAL) ||
      (p == ram_blk_pkg::PORT_A);
    localparam bit ALLOW_RD =
      (RAM_CFG == ram_blk_pkg::CFG_TRUE_DUAL) ||
      (RAM_CFG == ram_blk_pkg::CFG_SINGLE_PORT &&
       p == ram_blk_pkg::PORT_A) ||
      (RAM_CFG == ram_blk_pkg::CFG_SIMPLE_DUAL &&
       p == ram_blk_pkg::PORT_B);

    logic [ADDR_W-1:0] addr_last_r;
    logic [DATA_W-1:0] read_r;
    logic [DATA_W-1:0] read_nxt;

    // Port A is the write side and port B the read side when split.
    if (CLK_SCHEME == ram_blk_pkg::SCHEME_SPLIT) begin : g_split
      if (p == ram_blk_pkg::PORT_A) begin : g_wside
        assign port_ce[p] = wr_clk_en;
      end else begin : g_rside
        assign port_ce[p] = rd_clk_en;
      end
    end else begin : g_single
      assign port_ce[p] = clk_en;
    end

    // A held address reuses the one taken at the last enabled edge.
    assign eff_addr[p] = req[p].addr_hold ? addr_last_r : req[p].addr;
    assign wr_data[p]  = req[p].data;
    assign wr_be[p]    = req[p].byte_en;

    // Nothing is taken on an edge whose enable is low.
    assign wr_go[p] = port_ce[p] && ALLOW_WR && req[p].wr_en;
    assign rd_go[p] = port_ce[p] && ALLOW_RD && req[p].rd_en;

    // The reset only models power-up; it never reaches the array.
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        addr_last_r <= ram_blk_pkg::ADDR_RST;
      end else if (port_ce[p]) begin
        addr_last_r <= eff_addr[p];
      end
    end

    // Own written bytes flow through; other bytes come from the array,
    // which still holds the word from before this edge.
    always_comb begin
      read_nxt = rd_old[p];
      if (wr_go[p]) begin
        for (int b = 0; b < BYTES; b++) begin
          if (wr_be[p][b]) begin
            read_nxt[b*BYTE_W +: BYTE_W] =
              wr_data[p][b*BYTE_W +: BYTE_W];
          end
        end
      end
    end

    // A same-port write updates the output, as if it were a read, on a port allowed to read.
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        read_r <= ram_blk_pkg::RDATA_RST;
      end else if (rd_go[p] || (wr_go[p] && ALLOW_RD)) begin
        read_r <= read_nxt;
      end
    end

    if (OUT_REG[p]) begin : g_oreg
      logic [DATA_W-1:0] out_r;

      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          out_r <= ram_blk_pkg::RDATA_RST;
        end else if (port_ce[p]) begin
          out_r <= read_r;
        end
      end
      assign rdata[p] = out_r;
    end else begin : g_bypass
      assign rdata[p] = read_r;
    end

  end

  assign a_rdata = rdata[ram_blk_pkg::PORT_A];
  assign b_rdata = rdata[ram_blk_pkg::PORT_B];

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  ram_array #(
    .ADDR_W     (ADDR_W),
    .DATA_W     (DATA_W),
    .BYTE_W     (BYTE_W),
    .INIT_IMAGE (INIT_IMAGE)
  ) u_array (
    .sys_clk (sys_clk),
    .wr_go   (wr_go),
    .wr_addr (eff_addr),
    .wr_data (wr_data),
    .wr_be   (wr_be),
    .rd_addr (eff_addr),
    .rd_old  (rd_old)
  );

  // ----------------------------------------------------------------------
  // Contention status
  // ----------------------------------------------------------------------
  // These only report; the array is not protected. Keeping clear of both
  // cases is the user logic's job, and the flags help catch a slip.
  logic same_addr;
  logic collide_nxt;
  logic mixed_nxt;

  assign same_addr = (eff_addr[ram_blk_pkg::PORT_A] ==
                      eff_addr[ram_blk_pkg::PORT_B]);

  // Both ports writing one word keeps port B's bytes wherever both write.
  assign collide_nxt = same_addr &&
                       wr_go[ram_blk_pkg::PORT_A] &&
                       wr_go[ram_blk_pkg::PORT_B];

  // Cross-port read of a word being written returns the old word here.
  assign mixed_nxt = same_addr &&
                     ((wr_go[ram_blk_pkg::PORT_A] &&
                       rd_go[ram_blk_pkg::PORT_B]) ||
                      (wr_go[ram_blk_pkg::PORT_B] &&
                       rd_go[ram_blk_pkg::PORT_A]));

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_collide <= 1'b0;
    end else begin
      wr_collide <= collide_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mixed_rdw <= 1'b0;
    end else begin
      mixed_rdw <= mixed_nxt;
    end
  end

endmodule
`default_nettype wire

// file: rtl/ram_blk_pkg.sv
`default_nettype none
package ram_blk_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int BYTES  = DATA_W / BYTE_W;
  localparam int DEPTH  = 1 << ADDR_W;
  localparam int PORTS  = 2;

  // ----------------------------------------------------------------------
  // Port indices
  // ----------------------------------------------------------------------
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [DATA_W-1:0] RDATA_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 8'h00;

  // ----------------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------------
  typedef enum {
    SCHEME_SPLIT,
    SCHEME_SINGLE
  } clk_scheme_t;

  typedef enum {
    CFG_SINGLE_PORT,
    CFG_SIMPLE_DUAL,
    CFG_TRUE_DUAL
  } ram_cfg_t;

  // ----------------------------------------------------------------------
  // One port's request, as user logic presents it
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [BYTES-1:0]  byte_en;
    logic              wr_en;
    logic              rd_en;
    logic              addr_hold;
  } ram_req_t;

endpackage
`default_nettype wire
